// ### rtl/fpbox_cfg.svh
// Offsets, field values and counts for the floating point box
`ifndef FPBOX_CFG_SVH
`define FPBOX_CFG_SVH
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define SUM_OFFSET 8'h08
`define CTRL_RESET 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define TRAP_ADDR 8'h44
`define EXP_OVF_LIMIT 10'h040
`define EXP_UNF_LIMIT 10'h3c0
`define EXP_HOLD_HI 10'h060
`define EXP_HOLD_LO 10'h3a0
`define SIG_MAX_SHIFTS 4'h2
`define MUL_ITERS 6'h06
`define DIV_ITERS 6'h1c
`endif

// ### rtl/fpbox_pkg.sv
// Types shared by the floating point box and its users
package fpbox_pkg;
  typedef enum logic [3:0] {IDLE, PH1, PH2, PH3, PH4, PH5, PH6, PH7, PH8, PH9, PH10} phase_t;
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} fp_op_t;
  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_SUM, SEL_NONE} reg_sel_t;
  typedef struct packed {
    logic [1:0] disp_sel;
    logic sum_display_mode;
    logic zero_on_underflow_flag;
    logic significance_trap_flag;
    logic no_normalize_flag;
  } ctrl_t;
  typedef struct packed {
    logic trap;
    logic polarity_reversed;
    logic exponent_underflow_flag;
    logic exponent_overflow_flag;
    logic result_zero;
    logic [3:0] phase;
  } status_t;
  typedef struct packed {
    logic unit_start_control;
    fp_op_t op;
    logic reg_addr_lsb;
  } cpu_req_t;
endpackage

// ### rtl/floating_point_box_datapath.sv
// Floating point box: hex-exponent add, subtract, multiply, divide with AXI4-Lite control
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "fpbox_cfg.svh"
module floating_point_box_datapath (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fpbox_pkg::cpu_req_t cpu_req,
  input wire logic [0:31] shared_transfer_bus_in,
  output logic [0:31] shared_transfer_bus_out,
  output logic shared_transfer_bus_oe,
  output logic result_ready,
  output logic scratchpad_write_set,
  output logic floating_trap,
  output logic [7:0] trap_address
);
  import fpbox_pkg::*;

  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    logic [7:0] w;
    w = {addr[7:2], 2'h0};
    if (w == `CTRL_OFFSET) decode_addr = SEL_CTRL;
    else if (w == `STATUS_OFFSET) decode_addr = SEL_STATUS;
    else if (w == `SUM_OFFSET) decode_addr = SEL_SUM;
    else decode_addr = SEL_NONE;
  endfunction

  function automatic logic signed [31:0] unpack_mant(input logic [0:31] w);
    logic [31:0] m;
    m = {4'h0, w[8:31], 4'h0};
    unpack_mant = w[0] ? -m : m;
  endfunction

  // Exponent field arrives excess-64; flipping its top bit gives two's complement
  function automatic logic signed [9:0] unpack_exp(input logic [0:31] w);
    unpack_exp = {{3{~w[1]}}, ~w[1], w[2:7]};
  endfunction

  // Sign plus leading hex digit; bits 30:28 are only adder headroom
  function automatic logic simple_norm(input logic [31:0] x);
    simple_norm = !({x[31], x[27:24]} == 5'h00 || {x[31], x[27:24]} == 5'h1f);
  endfunction

  function automatic logic signed [9:0] exp_step(input logic signed [9:0] e, input logic up);
    if (up) exp_step = (e > $signed(`EXP_HOLD_HI)) ? e : e + 10'sh001;
    else exp_step = (e < $signed(`EXP_HOLD_LO)) ? e : e - 10'sh001;
  endfunction

  // Register bus
  ctrl_t ctrl_ff, nxt_ctrl;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  status_t status;

  // Datapath
  phase_t phase_ff, nxt_phase;
  fp_op_t op_ff, nxt_op;
  logic signed [31:0] a_ff, nxt_a, d_ff, nxt_d;
  logic [47:0] b_ff, nxt_b;
  logic [28:0] rem_ff, nxt_rem;
  logic signed [9:0] ea_ff, nxt_ea, ed_ff, nxt_ed, e_ff, nxt_e;
  logic operand_sign_ff, nxt_operand_sign, reg_sign_ff, nxt_reg_sign, fsign_ff, nxt_fsign;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [3:0] nshift_ff, nxt_nshift;
  logic r31_ff, nxt_r31, result_zero_ff, nxt_result_zero;
  logic ovf_ff, nxt_ovf, unf_ff, nxt_unf, trap_pend_ff, nxt_trap_pend;
  logic result_ready_ff, nxt_result_ready, spw_ff, nxt_spw, trap_ff, nxt_trap;
  logic [7:0] trap_addr_ff, nxt_trap_addr;
  logic [0:31] bus_out_ff, nxt_bus_out;
  logic bus_oe_ff, nxt_bus_oe, word_ff, nxt_word;

  logic is_addsub, a_norm_raw, a_operand_normalized, d_operand_normalized;
  logic invert_both_propagate, lowest_carry_in, bit71_carry_in;
  logic multiply_iterate, divide_iterate, polarity_reversed;
  logic [31:0] add_x, add_y, sum_bus, mag_a, mag_d;
  logic [28:0] rem2;
  logic zero_res, ovf_raw, unf_raw, sig_trap, any_trap;

  always_comb begin
    is_addsub = (op_ff == OP_ADD) || (op_ff == OP_SUB);
    a_norm_raw = simple_norm(a_ff);
    a_operand_normalized = a_norm_raw || (ctrl_ff.no_normalize_flag && is_addsub);
    d_operand_normalized = simple_norm(d_ff);
    // Tenth phase reuses the adder to complement a negative result
    invert_both_propagate = (phase_ff == PH4 && op_ff == OP_SUB) || (phase_ff == PH10 && a_ff[31]);
    lowest_carry_in = invert_both_propagate && !ctrl_ff.sum_display_mode;
    bit71_carry_in = lowest_carry_in && phase_ff == PH10;
    add_x = (phase_ff == PH10) ? 32'h0 : a_ff;
    add_y = (phase_ff == PH10) ? a_ff : d_ff;
    if (invert_both_propagate) add_y = ~add_y;
    if (ctrl_ff.sum_display_mode) begin
      case (ctrl_ff.disp_sel)
        2'h0: sum_bus = a_ff;
        2'h1: sum_bus = b_ff[47:16];
        2'h2: sum_bus = d_ff;
        default: sum_bus = 32'h0;
      endcase
    end else begin
      sum_bus = add_x + add_y + {31'h0, lowest_carry_in};
    end
    mag_a = a_ff[31] ? -a_ff : a_ff;
    mag_d = d_ff[31] ? -d_ff : d_ff;
    rem2 = {rem_ff[27:0], 1'b0};
    multiply_iterate = phase_ff == PH7 && cnt_ff < `MUL_ITERS;
    divide_iterate = phase_ff == PH8 && cnt_ff < `DIV_ITERS;
    polarity_reversed = fsign_ff != a_ff[31];
    zero_res = sum_bus[27:0] == 28'h0;
    ovf_raw = (e_ff >= $signed(`EXP_OVF_LIMIT)) && !zero_res;
    unf_raw = (e_ff < $signed(`EXP_UNF_LIMIT)) && !zero_res;
    sig_trap = is_addsub && ctrl_ff.significance_trap_flag
               && (nshift_ff > `SIG_MAX_SHIFTS || zero_res);
    any_trap = trap_pend_ff || ovf_raw || sig_trap
               || (unf_raw && ctrl_ff.zero_on_underflow_flag);

    nxt_phase = phase_ff;
    nxt_op = op_ff;
    nxt_a = a_ff;
    nxt_d = d_ff;
    nxt_b = b_ff;
    nxt_rem = rem_ff;
    nxt_ea = ea_ff;
    nxt_ed = ed_ff;
    nxt_e = e_ff;
    nxt_operand_sign = operand_sign_ff;
    nxt_reg_sign = reg_sign_ff;
    nxt_fsign = fsign_ff;
    nxt_cnt = cnt_ff;
    nxt_nshift = nshift_ff;
    nxt_r31 = r31_ff;
    nxt_result_zero = result_zero_ff;
    nxt_ovf = ovf_ff;
    nxt_unf = unf_ff;
    nxt_trap_pend = trap_pend_ff;
    nxt_spw = 1'b0;
    nxt_trap = 1'b0;
    nxt_trap_addr = trap_addr_ff;
    nxt_bus_out = bus_out_ff;
    nxt_bus_oe = bus_oe_ff;
    nxt_word = word_ff;
    case (phase_ff)
      IDLE: begin
        if (cpu_req.unit_start_control) begin
          nxt_phase = PH1;
          nxt_op = cpu_req.op;
          nxt_r31 = cpu_req.reg_addr_lsb;
          nxt_trap_pend = 1'b0;
          nxt_ovf = 1'b0;
          nxt_unf = 1'b0;
        end
      end
      PH1: begin
        nxt_operand_sign = shared_transfer_bus_in[0];
        nxt_d = unpack_mant(shared_transfer_bus_in);
        nxt_ed = unpack_exp(shared_transfer_bus_in);
        nxt_phase = PH2;
      end
      PH2: begin
        nxt_reg_sign = shared_transfer_bus_in[0];
        nxt_a = unpack_mant(shared_transfer_bus_in);
        nxt_ea = unpack_exp(shared_transfer_bus_in);
        nxt_b = 48'h0;
        nxt_phase = PH3;
      end
      PH3: begin
        nxt_fsign = operand_sign_ff ^ reg_sign_ff;
        if (is_addsub) begin
          // One hex digit of alignment per clock
          if (ea_ff == ed_ff) nxt_phase = PH4;
          else if (ea_ff > ed_ff) begin
            nxt_d = d_ff >>> 4;
            nxt_ed = (d_ff == 32'h0) ? ea_ff : ed_ff + 10'sh001;
          end else begin
            nxt_a = a_ff >>> 4;
            nxt_ea = (a_ff == 32'h0) ? ed_ff : ea_ff + 10'sh001;
          end
        end else if (a_ff == 32'h0 || (d_ff == 32'h0 && op_ff == OP_MUL)) begin
          nxt_a = 32'h0;
          nxt_phase = PH10;
        end else if (d_ff == 32'h0) begin
          nxt_trap_pend = 1'b1;
          nxt_phase = PH10;
        end else if (!a_norm_raw) begin
          nxt_a = a_ff <<< 4;
          nxt_ea = ea_ff - 10'sh001;
        end else if (!d_operand_normalized) begin
          nxt_d = d_ff <<< 4;
          nxt_ed = ed_ff - 10'sh001;
        end else if (op_ff == OP_MUL) begin
          nxt_phase = PH6;
        end else begin
          nxt_rem = {5'h00, mag_a[27:4]};
          // Divisor sits one hex digit above the dividend in the compare window
          nxt_d = {4'h0, mag_d[27:0]};
          nxt_e = ea_ff - ed_ff + 10'sh001;
          nxt_cnt = 6'h00;
          nxt_phase = PH8;
        end
      end
      PH4: begin
        nxt_a = sum_bus;
        nxt_fsign = sum_bus[31];
        nxt_e = ea_ff;
        nxt_nshift = 4'h0;
        nxt_phase = PH5;
      end
      PH5: begin
        if (a_ff[31:28] != {4{a_ff[31]}}) begin
          nxt_a = a_ff >>> 4;
          nxt_e = exp_step(e_ff, 1'b1);
        end else if (a_ff == 32'h0 && b_ff == 48'h0) begin
          nxt_phase = PH10;
        end else if (!a_operand_normalized) begin
          nxt_a = {a_ff[27:0], b_ff[47:44]};
          nxt_b = {b_ff[43:0], 4'h0};
          nxt_e = exp_step(e_ff, 1'b0);
          if (nshift_ff != 4'hf) nxt_nshift = nshift_ff + 4'h1;
        end else begin
          nxt_phase = PH10;
        end
      end
      PH6: begin
        nxt_a = mag_a;
        nxt_d = mag_d;
        nxt_b = 48'h0;
        nxt_cnt = 6'h00;
        nxt_e = ea_ff + ed_ff;
        nxt_phase = PH7;
      end
      PH7: begin
        if (multiply_iterate) begin
          nxt_b = {b_ff[43:0], 4'h0} + {20'h0, 28'(a_ff[27:4] * d_ff[27:24])};
          nxt_d = d_ff <<< 4;
          nxt_cnt = cnt_ff + 6'h01;
        end else begin
          nxt_a = {4'h0, b_ff[47:20]};
          // Short product keeps only the high word
          nxt_b = r31_ff ? 48'h0 : {b_ff[19:0], 28'h0};
          nxt_nshift = 4'h0;
          nxt_phase = PH5;
        end
      end
      PH8: begin
        if (divide_iterate) begin
          if (rem2 >= d_ff[28:0]) nxt_rem = rem2 - d_ff[28:0];
          else nxt_rem = rem2;
          nxt_b = {b_ff[46:0], rem2 >= d_ff[28:0]};
          nxt_cnt = cnt_ff + 6'h01;
        end else if (cnt_ff == `DIV_ITERS) begin
          nxt_a = {4'h0, b_ff[27:0]};
          nxt_b = 48'h0;
          nxt_cnt = cnt_ff + 6'h01;
        end else begin
          nxt_nshift = 4'h0;
          nxt_phase = PH5;
        end
      end
      PH10: begin
        nxt_a = sum_bus;
        nxt_result_zero = zero_res;
        nxt_ovf = ovf_raw;
        nxt_unf = unf_raw && !(sig_trap && !ctrl_ff.zero_on_underflow_flag);
        nxt_trap_pend = any_trap;
        nxt_trap = any_trap;
        nxt_trap_addr = any_trap ? `TRAP_ADDR : 8'h00;
        nxt_spw = !any_trap;
        nxt_bus_oe = 1'b1;
        nxt_word = 1'b0;
        if (zero_res || (unf_raw && !ctrl_ff.zero_on_underflow_flag)) begin
          nxt_bus_out = 32'h0;
          nxt_a = 32'h0;
          nxt_b = 48'h0;
        end else begin
          nxt_bus_out = {fsign_ff, ~e_ff[6], e_ff[5:0], sum_bus[27:4]};
        end
        nxt_phase = PH9;
      end
      PH9: begin
        if (!word_ff) begin
          nxt_bus_out = {8'h00, a_ff[3:0], b_ff[47:28]};
          nxt_spw = !trap_pend_ff;
          nxt_word = 1'b1;
        end else begin
          nxt_bus_oe = 1'b0;
          nxt_phase = IDLE;
        end
      end
      default: nxt_phase = IDLE;
    endcase
    nxt_result_ready = nxt_phase == PH10;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= IDLE;
      op_ff <= OP_ADD;
      a_ff <= 32'sh0;
      d_ff <= 32'sh0;
      b_ff <= 48'h0;
      rem_ff <= 29'h0;
      ea_ff <= 10'sh0;
      ed_ff <= 10'sh0;
      e_ff <= 10'sh0;
      operand_sign_ff <= 1'b0;
      reg_sign_ff <= 1'b0;
      fsign_ff <= 1'b0;
      cnt_ff <= 6'h00;
      nshift_ff <= 4'h0;
      r31_ff <= 1'b0;
      result_zero_ff <= 1'b0;
      ovf_ff <= 1'b0;
      unf_ff <= 1'b0;
      trap_pend_ff <= 1'b0;
      result_ready_ff <= 1'b0;
      spw_ff <= 1'b0;
      trap_ff <= 1'b0;
      trap_addr_ff <= 8'h00;
      bus_out_ff <= 32'h0;
      bus_oe_ff <= 1'b0;
      word_ff <= 1'b0;
    end else if (ce) begin
      phase_ff <= nxt_phase;
      op_ff <= nxt_op;
      a_ff <= nxt_a;
      d_ff <= nxt_d;
      b_ff <= nxt_b;
      rem_ff <= nxt_rem;
      ea_ff <= nxt_ea;
      ed_ff <= nxt_ed;
      e_ff <= nxt_e;
      operand_sign_ff <= nxt_operand_sign;
      reg_sign_ff <= nxt_reg_sign;
      fsign_ff <= nxt_fsign;
      cnt_ff <= nxt_cnt;
      nshift_ff <= nxt_nshift;
      r31_ff <= nxt_r31;
      result_zero_ff <= nxt_result_zero;
      ovf_ff <= nxt_ovf;
      unf_ff <= nxt_unf;
      trap_pend_ff <= nxt_trap_pend;
      result_ready_ff <= nxt_result_ready;
      spw_ff <= nxt_spw;
      trap_ff <= nxt_trap;
      trap_addr_ff <= nxt_trap_addr;
      bus_out_ff <= nxt_bus_out;
      bus_oe_ff <= nxt_bus_oe;
      word_ff <= nxt_word;
    end
  end

  always_comb begin
    status = '{trap: trap_pend_ff, polarity_reversed: polarity_reversed,
               exponent_underflow_flag: unf_ff, exponent_overflow_flag: ovf_ff,
               result_zero: result_zero_ff, phase: phase_ff};
    nxt_ctrl = ctrl_ff;
    nxt_aw_have = aw_have_ff | (s_axi_awvalid & awready_ff);
    nxt_awaddr = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : awaddr_ff;
    nxt_w_have = w_have_ff | (s_axi_wvalid & wready_ff);
    nxt_wdata = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wdata_ff;
    nxt_wstrb = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wstrb_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    if (aw_have_ff && w_have_ff && !bvalid_ff) begin
      // Only the control word is writable; status and sum writes are dropped
      nxt_bresp = (decode_addr(awaddr_ff) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (decode_addr(awaddr_ff) == SEL_CTRL && wstrb_ff[0]) nxt_ctrl = wdata_ff[5:0];
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
    end
    nxt_awready = !nxt_aw_have;
    nxt_wready = !nxt_w_have;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      case (decode_addr(s_axi_araddr))
        SEL_CTRL: nxt_rdata = {26'h0, ctrl_ff};
        SEL_STATUS: nxt_rdata = {23'h0, status};
        SEL_SUM: nxt_rdata = sum_bus;
        default: begin
          nxt_rdata = 32'h0;
          nxt_rresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `CTRL_RESET;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      arready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 32'h0;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign shared_transfer_bus_out = bus_out_ff;
  assign shared_transfer_bus_oe = bus_oe_ff;
  assign result_ready = result_ready_ff;
  assign scratchpad_write_set = spw_ff;
  assign floating_trap = trap_ff;
  assign trap_address = trap_addr_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ready_then_out;
    ce && result_ready_ff ##1 phase_ff == PH9 && bus_oe_ff;
  endsequence

  a_start_phase: assert property (ce && phase_ff == IDLE && cpu_req.unit_start_control
    |=> phase_ff == PH1) else $error("start did not enter first phase");
  a_sign_latch: assert property (ce && phase_ff == PH1
    |=> operand_sign_ff == $past(shared_transfer_bus_in[0])) else $error("sign not latched");
  a_ready_lead: assert property (ce && result_ready_ff |-> phase_ff == PH10
    ##0 s_ready_then_out) else $error("ready not one clock before output");
  a_nonorm_force: assert property (ctrl_ff.no_normalize_flag && is_addsub
    |-> a_operand_normalized) else $error("normalize test not forced");
  a_ovf_flag: assert property (ce && phase_ff == PH10 && e_ff >= $signed(`EXP_OVF_LIMIT)
    && !zero_res |=> ovf_ff && floating_trap) else $error("overflow missed");
  a_exp_hold_lo: assert property (ce && phase_ff == PH5 && e_ff < $signed(`EXP_HOLD_LO)
    |=> e_ff <= $past(e_ff)) else $error("downcount below hold");
  a_display_kill: assert property (ctrl_ff.sum_display_mode
    |-> !lowest_carry_in && sum_bus == (ctrl_ff.disp_sel == 2'h0 ? a_ff
    : ctrl_ff.disp_sel == 2'h1 ? b_ff[47:16] : ctrl_ff.disp_sel == 2'h2 ? d_ff : 32'h0))
    else $error("display leaked carries");
  a_tenth_carry: assert property (phase_ff == PH10 && a_ff[31] && !ctrl_ff.sum_display_mode
    |-> bit71_carry_in && lowest_carry_in) else $error("tenth phase carry not forced");
  a_mul_iter: assert property (ce && phase_ff == PH6
    |=> multiply_iterate [*6] ##1 (phase_ff == PH7 && !multiply_iterate))
    else $error("multiply iterate length");
  a_div_iter: assert property (divide_iterate |-> phase_ff == PH8
    && cnt_ff < `DIV_ITERS) else $error("divide iterate outside window");
  a_trap_block: assert property (ce && floating_trap |-> trap_address == `TRAP_ADDR
    && !scratchpad_write_set ##1 !scratchpad_write_set) else $error("trap let write through");
endmodule

// ### bench/cpu_host_model.sv
// Host processor model: starts the box and drives operands on the shared bus
`timescale 1ns/1ps
module cpu_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire fpbox_pkg::fp_op_t op,
  input wire logic lsb,
  input wire logic [0:31] mem_word,
  input wire logic [0:31] reg_word,
  input wire logic [0:31] box_out,
  input wire logic box_oe,
  output fpbox_pkg::cpu_req_t cpu_req,
  output logic [0:31] bus_in
);
  import fpbox_pkg::*;
  logic [1:0] step_ff;
  logic [0:31] drv_ff;
  // Released bus toggles every cycle except the start cycle and the two operand cycles, so stale operands never look valid
  assign bus_in = box_oe ? box_out : drv_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_ff <= 2'h0;
      cpu_req <= '0;
      drv_ff <= 32'h0;
    end else if (go && step_ff == 2'h0) begin
      cpu_req <= '{1'b1, op, lsb};
      step_ff <= 2'h1;
    end else begin
      cpu_req.unit_start_control <= 1'b0;
      step_ff <= (step_ff == 2'h0) ? 2'h0 : step_ff + 2'h1;
      drv_ff <= (step_ff == 2'h1) ? mem_word : (step_ff == 2'h2) ? reg_word : ~drv_ff;
    end
  end
endmodule

// ### bench/floating_point_box_datapath_bench.sv
// Self-checking bench for the floating point box datapath
`timescale 1ns/1ps
`include "fpbox_cfg.svh"
module floating_point_box_datapath_bench;
  import fpbox_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, go, lsb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, trap_address;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [0:31] shared_transfer_bus_in, shared_transfer_bus_out, mem_word, reg_word;
  logic shared_transfer_bus_oe, result_ready, scratchpad_write_set, floating_trap;
  cpu_req_t cpu_req;
  fp_op_t op;
  int miscompares, samples_checked;
  floating_point_box_datapath dut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req, .shared_transfer_bus_in,
    .shared_transfer_bus_out, .shared_transfer_bus_oe, .result_ready, .scratchpad_write_set,
    .floating_trap, .trap_address);
  cpu_host_model host (.aclk, .aresetn, .go, .op, .lsb, .mem_word, .reg_word,
    .box_out(shared_transfer_bus_out), .box_oe(shared_transfer_bus_oe), .cpu_req,
    .bus_in(shared_transfer_bus_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    check("bvalid", 32'(s_axi_bvalid), 32'h1);
    s_axi_bready <= 1'b0;
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    check("rvalid", 32'(s_axi_rvalid), 32'h1);
    s_axi_rready <= 1'b0;
    check("rresp", 32'(s_axi_rresp), 32'(er));
    check("rdata", s_axi_rdata, ed);
  endtask
  // Word contents are only defined when no trap blocks the write
  task automatic run_op(input fp_op_t o, input logic l, input logic [0:31] m,
    input logic [0:31] r, input logic [0:31] hi, input logic t);
    int n;
    n = 0;
    @(posedge aclk);
    op <= o;
    lsb <= l;
    mem_word <= m;
    reg_word <= r;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (result_ready !== 1'b1 && n < 500);
    check("ready", 32'(result_ready), 32'h1);
    check("oe_early", 32'(shared_transfer_bus_oe), 32'h0);
    @(posedge aclk);
    #1;
    check("oe", 32'(shared_transfer_bus_oe), 32'h1);
    check("trap", 32'(floating_trap), 32'(t));
    check("spw_hi", 32'(scratchpad_write_set), 32'(!t));
    if (t) check("taddr", 32'(trap_address), 32'(`TRAP_ADDR));
    if (!t) check("upper", shared_transfer_bus_out, hi);
    @(posedge aclk);
    #1;
    if (!t) check("lower", shared_transfer_bus_out, 32'h0);
    check("spw_lo", 32'(scratchpad_write_set), 32'(!t));
    @(posedge aclk);
    #1;
    check("oe_end", 32'(shared_transfer_bus_oe), 32'h0);
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, go, lsb, mem_word, reg_word} = '0;
    s_axi_wstrb = 4'hf;
    op = OP_ADD;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`CTRL_OFFSET, `RESP_OKAY, 32'(`CTRL_RESET));
    axi_rd(`STATUS_OFFSET, `RESP_OKAY, 32'h0);
    axi_rd(8'h0c, `RESP_SLVERR, 32'h0);
    axi_wr(8'h0c, 32'h3f, `RESP_SLVERR);
    axi_wr(`STATUS_OFFSET, 32'h1ff, `RESP_OKAY);
    axi_rd(`STATUS_OFFSET, `RESP_OKAY, 32'h0);
    axi_wr(`CTRL_OFFSET, 32'h38, `RESP_OKAY);
    axi_rd(`CTRL_OFFSET, `RESP_OKAY, 32'h38);
    axi_rd(`SUM_OFFSET, `RESP_OKAY, 32'h0);
    axi_wr(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    run_op(OP_ADD, 1'b0, 32'h40800000, 32'h40800000, 32'h41100000, 1'b0);
    run_op(OP_ADD, 1'b0, 32'hc0800000, 32'h40400000, 32'hc0400000, 1'b0);
    run_op(OP_SUB, 1'b0, 32'h40800000, 32'h40800000, 32'h0, 1'b0);
    run_op(OP_SUB, 1'b0, 32'h40780000, 32'h40800000, 32'h3f800000, 1'b0);
    run_op(OP_MUL, 1'b1, 32'h40800000, 32'h40800000, 32'h40400000, 1'b0);
    run_op(OP_MUL, 1'b0, 32'h40800000, 32'h40800000, 32'h40400000, 1'b0);
    run_op(OP_DIV, 1'b0, 32'h40800000, 32'h40800000, 32'h41100000, 1'b0);
    run_op(OP_DIV, 1'b0, 32'h0, 32'h40800000, 32'h0, 1'b1);
    run_op(OP_MUL, 1'b0, 32'h01100000, 32'h01100000, 32'h0, 1'b0);
    run_op(OP_MUL, 1'b0, 32'h7f100000, 32'h7f100000, 32'h0, 1'b1);
    axi_wr(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    run_op(OP_SUB, 1'b0, 32'h40780000, 32'h40800000, 32'h40080000, 1'b0);
    axi_wr(`CTRL_OFFSET, 32'h2, `RESP_OKAY);
    run_op(OP_ADD, 1'b0, 32'h40800000, 32'hc0800000, 32'h0, 1'b1);
    axi_wr(`CTRL_OFFSET, 32'h4, `RESP_OKAY);
    run_op(OP_MUL, 1'b0, 32'h01100000, 32'h01100000, 32'h0, 1'b1);
    // A keeps the normalized product mantissa of one sixteenth
    axi_wr(`CTRL_OFFSET, 32'h08, `RESP_OKAY);
    axi_rd(`SUM_OFFSET, `RESP_OKAY, 32'h01000000);
    summarize();
  end
endmodule
